// file: core/ssm_regs.svh
`ifndef SSM_REGS_SVH
`define SSM_REGS_SVH

// Status codes returned on the slave data output
`define SSM_CODE_HEADER  8'h55
`define SSM_CODE_WRITE   8'haa
`define SSM_CODE_ERROR   8'hee

// Transfer unit and header layout
`define SSM_BIT_FIRST    3'h0
`define SSM_BIT_LAST     3'h7
`define SSM_DIR_BIT      0
`define SSM_DIR_READ     1'h1
`define SSM_ADDR_LO_MSB  6
`define SSM_ADDR_HI_LSB  7
`define SSM_ADDR_HI_MSB  14
`define SSM_ONE_BYTE     8'h01
`define SSM_ZERO_BYTE    8'h00
`define SSM_ADDR_STEP    15'h0001

// Synchroniser: bit 0 is slave select (idles high), bit 1 the byte toggle
`define SSM_SYNC_INIT    2'h1
`define SSM_SYNC_SS      0
`define SSM_SYNC_TGL     1

// One message is pending after reset to flag end of initialisation
`define SSM_RESET_MSGS   8'h01
`define SSM_MSGS_MAX     8'hff

`endif

// file: core/ssm_pkg.sv
package ssm_pkg;

   typedef logic [7:0]  ssm_byte_type;
   typedef logic [14:0] ssm_addr_type;

   typedef enum logic [2:0] {
      SSM_HDR0,
      SSM_HDR1,
      SSM_HDR2,
      SSM_WDATA,
      SSM_RDATA,
      SSM_DONE,
      SSM_REJECT
   } ssm_state_type;

endpackage : ssm_pkg

// file: core/ssm_spi_slave.sv
// Operation
// - Device is SPI slave; host drives clocks
// - Clock idles high; shift falling, sample rising
// - Each exchange opens with three header bytes
// - Header byte 0 bit 0: 1 read
// - Fifteen-bit address split over bytes 0, 1
// - Header byte 2 gives data byte count
// - Writes store bytes at incrementing addresses
// - Return 0x55 during header bytes
// - Return 0xAA during write data bytes
// - Return 0xEE after count exhausted
// - Read-only write: 0xEE, discard rest
// - Data output floats during sleep
// - Deep sleep only while select high
// - Reads return memory at incrementing addresses
// - Every transfer unit is eight bits
// - Message-pending pin low while message waits
`timescale 1ns/1ps
`default_nettype none
`include "ssm_regs.svh"

module ssm_spi_slave #(
   parameter int                   MEM_DEPTH = 1024,
   parameter int                   RO_LIMIT  = 64,
   parameter ssm_pkg::ssm_addr_type MSG_ADDR = 15'h0040
) (
   input  wire logic                  sys_clk_in,
   input  wire logic                  rst_in,
   input  wire logic                  sck_in,
   input  wire logic                  ss_n_in,
   input  wire logic                  mosi_in,
   output logic                       miso_out,
   output logic                       miso_oe_out,
   output logic                       chg_n_out,
   output logic                       chg_n_oe_out,
   input  wire logic                  low_power_mode_in,
   output logic                       deep_sleep_out,
   output logic                       light_sleep_out,
   input  wire logic                  msg_post_in,
   input  wire logic                  core_we_in,
   input  wire ssm_pkg::ssm_addr_type core_addr_in,
   input  wire ssm_pkg::ssm_byte_type core_wdata_in,
   output logic                       host_wr_out,
   output ssm_pkg::ssm_addr_type      host_wr_addr_out,
   output ssm_pkg::ssm_byte_type      host_wr_data_out,
   output logic                       busy_out,
   output logic                       reject_out,
   output logic                       overrun_out
);
   import ssm_pkg::*;

   localparam int         IDX_W     = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;
   localparam logic [1:0] SYNC_INIT = `SSM_SYNC_INIT;

   if (MEM_DEPTH < 1 || MEM_DEPTH > 32768 || RO_LIMIT < 0 || RO_LIMIT > MEM_DEPTH) begin : g_bad_params
      $error("ssm_spi_slave: MEM_DEPTH or RO_LIMIT out of range");
   end

   // ---------------------------------------------------------------
   // Link domain, clocked by the host's serial clock. Slave select high
   // clears it, so nothing here relies on edges outside a frame.
   // ---------------------------------------------------------------
   logic [2:0]   rx_cnt_q;
   ssm_byte_type rx_sh_q;
   ssm_byte_type rx_byte_q;
   logic         rx_tgl_q;
   ssm_byte_type tx_sh_q;
   ssm_byte_type tx_word_q;

   always_ff @(posedge sck_in or posedge ss_n_in) begin
      if (ss_n_in) begin
         rx_cnt_q <= `SSM_BIT_FIRST;
         rx_sh_q  <= `SSM_ZERO_BYTE;
      end else begin
         rx_cnt_q <= rx_cnt_q + 3'h1;
         rx_sh_q  <= {rx_sh_q[6:0], mosi_in};
      end
   end

   // Whole byte is handed over with a toggle; the word stays put for the
   // host's inter-byte gap, far longer than the synchroniser needs.
   always_ff @(posedge sck_in or posedge ss_n_in) begin
      if (ss_n_in) begin
         rx_byte_q <= `SSM_ZERO_BYTE;
         rx_tgl_q  <= 1'b0;
      end else if (rx_cnt_q == `SSM_BIT_LAST) begin
         rx_byte_q <= {rx_sh_q[6:0], mosi_in};
         rx_tgl_q  <= ~rx_tgl_q;
      end
   end

   // First falling edge of each byte loads the reply. tx_word_q is settled
   // by the system side well inside the host's inter-byte gap between the last bit and that edge.
   always_ff @(negedge sck_in or posedge ss_n_in) begin
      if (ss_n_in) begin
         tx_sh_q <= `SSM_ZERO_BYTE;
      end else if (rx_cnt_q == `SSM_BIT_FIRST) begin
         tx_sh_q <= tx_word_q;
      end else begin
         tx_sh_q <= {tx_sh_q[6:0], 1'b0};
      end
   end

   assign miso_out    = tx_sh_q[7];
   // Released while deselected or in either sleep phase of low power mode
   assign miso_oe_out = ~ss_n_in & ~low_power_mode_in;

   // ---------------------------------------------------------------
   // Synchronisers into the system clock: three stages, a change is taken
   // once stages two and three agree.
   // ---------------------------------------------------------------
   logic [1:0] sync_raw;
   logic [1:0] sync_stable;

   assign sync_raw = {rx_tgl_q, ss_n_in};

   for (genvar i = 0; i < 2; i++) begin : g_sync
      logic s1_q;
      logic s2_q;
      logic s3_q;
      logic stab_q;

      always_ff @(posedge sys_clk_in) begin
         if (rst_in) begin
            s1_q   <= SYNC_INIT[i];
            s2_q   <= SYNC_INIT[i];
            s3_q   <= SYNC_INIT[i];
            stab_q <= SYNC_INIT[i];
         end else begin
            s1_q <= sync_raw[i];
            s2_q <= s1_q;
            s3_q <= s2_q;
            if (s2_q == s3_q) begin
               stab_q <= s3_q;
            end
         end
      end

      assign sync_stable[i] = stab_q;
   end

   logic ss_high;
   logic tgl_seen_q;
   logic byte_ev;

   assign ss_high = sync_stable[`SSM_SYNC_SS];
   assign byte_ev = ~ss_high & (sync_stable[`SSM_SYNC_TGL] != tgl_seen_q);

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || ss_high) begin
         tgl_seen_q <= 1'b0;
      end else if (byte_ev) begin
         tgl_seen_q <= sync_stable[`SSM_SYNC_TGL];
      end
   end

   // ---------------------------------------------------------------
   // Object memory
   // ---------------------------------------------------------------
   ssm_byte_type mem [MEM_DEPTH];

   // Compared as int so a full 15-bit map does not wrap the limit to zero
   function automatic logic in_mem(input ssm_addr_type a);
      return int'(a) < MEM_DEPTH;
   endfunction

   function automatic ssm_byte_type rd_mem(input ssm_addr_type a);
      if (in_mem(a)) begin
         return mem[a[IDX_W-1:0]];
      end
      return `SSM_ZERO_BYTE;
   endfunction

   // Low region and anything past the memory are read-only to the host
   function automatic logic writable(input ssm_addr_type a);
      return in_mem(a) && (int'(a) >= RO_LIMIT);
   endfunction

   // ---------------------------------------------------------------
   // Exchange sequencer
   // ---------------------------------------------------------------
   ssm_state_type state_q;
   ssm_addr_type  addr_q;
   ssm_byte_type  remain_q;
   logic          dir_q;
   ssm_addr_type  addr_next;

   assign addr_next = addr_q + `SSM_ADDR_STEP;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in || ss_high) begin
         state_q   <= SSM_HDR0;
         addr_q    <= '0;
         remain_q  <= `SSM_ZERO_BYTE;
         dir_q     <= 1'b0;
         tx_word_q <= `SSM_CODE_HEADER;
      end else if (byte_ev) begin
         case (state_q)
            SSM_HDR0: begin
               addr_q[`SSM_ADDR_LO_MSB:0] <= rx_byte_q[7:1];
               dir_q                      <= rx_byte_q[`SSM_DIR_BIT];
               state_q                    <= SSM_HDR1;
            end
            SSM_HDR1: begin
               addr_q[`SSM_ADDR_HI_MSB:`SSM_ADDR_HI_LSB] <= rx_byte_q;
               state_q                                   <= SSM_HDR2;
            end
            SSM_HDR2: begin
               remain_q <= rx_byte_q;
               if (rx_byte_q == `SSM_ZERO_BYTE) begin
                  state_q   <= SSM_DONE;
                  tx_word_q <= `SSM_CODE_ERROR;
               end else if (dir_q == `SSM_DIR_READ) begin
                  state_q   <= SSM_RDATA;
                  tx_word_q <= rd_mem(addr_q);
               end else begin
                  state_q   <= SSM_WDATA;
                  tx_word_q <= `SSM_CODE_WRITE;
               end
            end
            SSM_WDATA: begin
               if (!writable(addr_q)) begin
                  state_q   <= SSM_REJECT;
                  tx_word_q <= `SSM_CODE_ERROR;
               end else begin
                  addr_q   <= addr_next;
                  remain_q <= remain_q - `SSM_ONE_BYTE;
                  if (remain_q == `SSM_ONE_BYTE) begin
                     state_q   <= SSM_DONE;
                     tx_word_q <= `SSM_CODE_ERROR;
                  end else begin
                     tx_word_q <= `SSM_CODE_WRITE;
                  end
               end
            end
            SSM_RDATA: begin
               addr_q   <= addr_next;
               remain_q <= remain_q - `SSM_ONE_BYTE;
               if (remain_q == `SSM_ONE_BYTE) begin
                  state_q   <= SSM_DONE;
                  tx_word_q <= `SSM_CODE_ERROR;
               end else begin
                  tx_word_q <= rd_mem(addr_next);
               end
            end
            default: begin
               tx_word_q <= `SSM_CODE_ERROR;
            end
         endcase
      end
   end

   logic host_write;

   assign host_write = byte_ev && (state_q == SSM_WDATA) && writable(addr_q);

   // Host writes win over the core in the same cycle; the core sees them
   // through host_wr_out and can repeat its own write if it must.
   always_ff @(posedge sys_clk_in) begin
      if (host_write) begin
         mem[addr_q[IDX_W-1:0]] <= rx_byte_q;
      end else if (core_we_in && in_mem(core_addr_in)) begin
         mem[core_addr_in[IDX_W-1:0]] <= core_wdata_in;
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         host_wr_out      <= 1'b0;
         host_wr_addr_out <= '0;
         host_wr_data_out <= `SSM_ZERO_BYTE;
      end else begin
         host_wr_out <= host_write;
         if (host_write) begin
            host_wr_addr_out <= addr_q;
            host_wr_data_out <= rx_byte_q;
         end
      end
   end

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         reject_out  <= 1'b0;
         overrun_out <= 1'b0;
      end else begin
         reject_out  <= byte_ev && (state_q == SSM_WDATA) && !writable(addr_q);
         overrun_out <= byte_ev && (state_q == SSM_DONE);
      end
   end

   // ---------------------------------------------------------------
   // Message-pending pin: open drain, only ever pulled low
   // ---------------------------------------------------------------
   ssm_byte_type pend_q;
   logic         msg_read;

   assign msg_read = byte_ev && (state_q == SSM_RDATA) && (addr_q == MSG_ADDR);

   // A post in the same cycle as a read keeps the count, so none is lost;
   // with nothing pending the read consumes nothing and the post still counts
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         pend_q <= `SSM_RESET_MSGS;
      end else if (msg_post_in && !(msg_read && pend_q != `SSM_ZERO_BYTE)) begin
         if (pend_q != `SSM_MSGS_MAX) begin
            pend_q <= pend_q + `SSM_ONE_BYTE;
         end
      end else if (msg_read && !msg_post_in && pend_q != `SSM_ZERO_BYTE) begin
         pend_q <= pend_q - `SSM_ONE_BYTE;
      end
   end

   assign chg_n_out = 1'b0;

   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         chg_n_oe_out <= 1'b0;
      end else begin
         chg_n_oe_out <= (pend_q != `SSM_ZERO_BYTE);
      end
   end

   // ---------------------------------------------------------------
   // Power-mode status to the rest of the device
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk_in) begin
      if (rst_in) begin
         deep_sleep_out  <= 1'b0;
         light_sleep_out <= 1'b0;
         busy_out        <= 1'b0;
      end else begin
         deep_sleep_out  <= low_power_mode_in & ss_high;
         light_sleep_out <= low_power_mode_in & ~ss_high;
         busy_out        <= ~ss_high;
      end
   end

endmodule // ssm_spi_slave

`default_nettype wire

// file: verification/ssm_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module ssm_host_model (
   output logic      sck_out,
   output logic      ss_n_out,
   output logic      mosi_out,
   input  wire logic miso_in
);
   import ssm_pkg::*;

   initial begin
      sck_out  = 1'b1;
      ss_n_out = 1'b1;
      mosi_out = 1'b0;
   end

   // Link clock runs only inside a byte; half period 6 ns
   task automatic put_byte(input ssm_byte_type tx, output ssm_byte_type rx);
      for (int i = 7; i >= 0; i--) begin
         #6 sck_out = 1'b0;
         mosi_out = tx[i];
         #6 sck_out = 1'b1;
         rx[i] = miso_in;
      end
      #6 mosi_out = ~mosi_out;
      // Shortened byte gap, still well above what the device needs
      #200;
   endtask

   // Gaps between exchanges are shortened so the run stays short
   task automatic frame(input logic open_in);
      #50 ss_n_out = ~open_in;
      #200;
   endtask
endmodule // ssm_host_model

`default_nettype wire

// file: verification/ssm_spi_slave_checker.sv
`timescale 1ns/1ps
`default_nettype none

module ssm_spi_slave_checker #(
   parameter int MEM_DEPTH = 1024,
   parameter int RO_LIMIT  = 64
) (
   input wire logic                  sys_clk_in,
   input wire logic                  rst_in,
   input wire logic                  ss_n_in,
   input wire logic                  low_power_mode_in,
   input wire logic                  miso_oe_out,
   input wire logic                  chg_n_out,
   input wire logic                  chg_n_oe_out,
   input wire logic                  deep_sleep_out,
   input wire logic                  light_sleep_out,
   input wire logic                  busy_out,
   input wire logic                  msg_post_in,
   input wire logic                  host_wr_out,
   input wire ssm_pkg::ssm_addr_type host_wr_addr_out,
   input wire logic                  reject_out
);
   import ssm_pkg::*;
   default clocking cb @(posedge sys_clk_in); endclocking
   default disable iff (rst_in);

   sequence s_sel_held;
      (!ss_n_in)[*6];
   endsequence
   sequence s_deep_held;
      (ss_n_in && low_power_mode_in)[*6];
   endsequence

   property p_oe; miso_oe_out == (!ss_n_in && !low_power_mode_in); endproperty
   a_oe: assert property (p_oe) else $error("miso enable wrong");
   property p_deep; s_deep_held |=> deep_sleep_out && !light_sleep_out; endproperty
   a_deep: assert property (p_deep) else $error("deep sleep missing");
   property p_light; light_sleep_out |-> !ss_n_in || $past(!ss_n_in, 6); endproperty
   a_light: assert property (p_light) else $error("light sleep without select");
   property p_busy; s_sel_held |=> busy_out && !deep_sleep_out; endproperty
   a_busy: assert property (p_busy) else $error("busy not raised");
   property p_chg; chg_n_out == 1'b0; endproperty
   a_chg: assert property (p_chg) else $error("message pin level wrong");
   property p_chg_quiet;
      !chg_n_oe_out && !msg_post_in && !$past(msg_post_in) && !$past(rst_in) |=> !chg_n_oe_out;
   endproperty
   a_chg_quiet: assert property (p_chg_quiet) else $error("message pin pulled with none queued");
   property p_msg; msg_post_in |-> ##[1:3] chg_n_oe_out; endproperty
   a_msg: assert property (p_msg) else $error("message pin not pulled");
   property p_rst; $fell(rst_in) |-> ##[0:3] chg_n_oe_out; endproperty
   a_rst: assert property (p_rst) else $error("no message after reset");
   property p_wr_ro; host_wr_out |-> host_wr_addr_out >= RO_LIMIT && host_wr_addr_out < MEM_DEPTH; endproperty
   a_wr_ro: assert property (p_wr_ro) else $error("read-only place written");
   property p_wr_pulse; host_wr_out |=> !host_wr_out; endproperty
   a_wr_pulse: assert property (p_wr_pulse) else $error("store pulse too long");
   property p_rej; reject_out |-> !host_wr_out ##1 !host_wr_out; endproperty
   a_rej: assert property (p_rej) else $error("rejected byte stored");
endmodule // ssm_spi_slave_checker

bind ssm_spi_slave ssm_spi_slave_checker #(.MEM_DEPTH(MEM_DEPTH), .RO_LIMIT(RO_LIMIT)) chk_u (
   .sys_clk_in, .rst_in, .ss_n_in, .low_power_mode_in, .miso_oe_out, .chg_n_out, .chg_n_oe_out,
   .deep_sleep_out, .light_sleep_out, .busy_out, .msg_post_in, .host_wr_out, .host_wr_addr_out, .reject_out);

`default_nettype wire

// file: verification/ssm_spi_slave_bench.sv
`timescale 1ns/1ps
`default_nettype none

module ssm_spi_slave_bench;
   import ssm_pkg::*;
   logic sys_clk_in = 1'b0, rst_in = 1'b1, lpm = 1'b0, post = 1'b0, cwe = 1'b0, miso_last = 1'b0;
   logic sck, ss_n, mosi, miso, miso_oe, chg_n, chg_oe, deep, light, wr, busy, rej, ovr;
   ssm_addr_type cadr = 15'h0000, wadr;
   ssm_byte_type cdat = 8'h00, wdat, rx_q[8], tx_q[8];
   ssm_addr_type wr_a[8];
   ssm_byte_type wr_d[8];
   int num_errors = 0, n_tests = 0, cyc = 0, wr_cnt = 0, rej_cnt = 0, ovr_cnt = 0;
   wire miso_w = miso_oe ? miso : ~miso_last;

   always #2 sys_clk_in = ~sys_clk_in;
   ssm_host_model host_u (.sck_out(sck), .ss_n_out(ss_n), .mosi_out(mosi), .miso_in(miso_w));
   ssm_spi_slave dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .sck_in(sck), .ss_n_in(ss_n),
      .mosi_in(mosi), .miso_out(miso), .miso_oe_out(miso_oe), .chg_n_out(chg_n), .chg_n_oe_out(chg_oe),
      .low_power_mode_in(lpm), .deep_sleep_out(deep), .light_sleep_out(light), .msg_post_in(post),
      .core_we_in(cwe), .core_addr_in(cadr), .core_wdata_in(cdat), .host_wr_out(wr),
      .host_wr_addr_out(wadr), .host_wr_data_out(wdat), .busy_out(busy), .reject_out(rej),
      .overrun_out(ovr));

   always @(posedge sys_clk_in) begin
      cyc <= cyc + 1;
      if (miso_oe) miso_last <= miso;
      if (wr === 1'b1) begin
         wr_a[wr_cnt % 8] <= wadr;
         wr_d[wr_cnt % 8] <= wdat;
         wr_cnt <= wr_cnt + 1;
      end
      if (rej === 1'b1) rej_cnt <= rej_cnt + 1;
      if (ovr === 1'b1) ovr_cnt <= ovr_cnt + 1;
      if (cyc == 20000) begin
         num_errors++;
         wrap_up();
      end
   end

   task automatic chk(input string nm, input logic [14:0] seen, input logic [14:0] exp);
      n_tests++;
      if (seen !== exp) begin
         num_errors++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic xchg(input ssm_addr_type a, input logic rd, input ssm_byte_type n, input int cnt);
      ssm_byte_type rx;
      host_u.frame(1'b1);
      for (int k = 0; k < cnt + 3; k++) begin
         host_u.put_byte(k == 0 ? {a[6:0], rd} : k == 1 ? a[14:7] : k == 2 ? n : tx_q[k - 3], rx);
         rx_q[k] = rx;
      end
      host_u.frame(1'b0);
      repeat (4) @(posedge sys_clk_in);
   endtask

   task automatic t_write();
      tx_q = '{8'h5a, 8'hc3, 8'h11, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
      xchg(15'h0100, 1'b0, 8'h02, 3);
      for (int k = 0; k < 3; k++) chk("hdr", rx_q[k], 15'h0055);
      chk("wd0", rx_q[3], 15'h00aa);
      chk("wd1", rx_q[4], 15'h00aa);
      chk("over", rx_q[5], 15'h00ee);
      chk("nwr", wr_cnt, 15'h0002);
      chk("a0", wr_a[0], 15'h0100);
      chk("d0", wr_d[0], 15'h005a);
      chk("a1", wr_a[1], 15'h0101);
      chk("d1", wr_d[1], 15'h00c3);
      chk("novr", ovr_cnt, 15'h0001);
   endtask

   task automatic t_read();
      @(posedge sys_clk_in);
      cwe <= 1'b1;
      cadr <= 15'h0102;
      cdat <= 8'h77;
      @(posedge sys_clk_in);
      cwe <= 1'b0;
      tx_q = '{default: 8'hff};
      xchg(15'h0100, 1'b1, 8'h03, 4);
      chk("r0", rx_q[3], 15'h005a);
      chk("r1", rx_q[4], 15'h00c3);
      chk("r2", rx_q[5], 15'h0077);
      chk("rov", rx_q[6], 15'h00ee);
      chk("rnwr", wr_cnt, 15'h0002);
   endtask

   task automatic t_ro();
      tx_q = '{default: 8'h34};
      xchg(15'h0010, 1'b0, 8'h02, 3);
      chk("ro0", rx_q[3], 15'h00aa);
      chk("ro1", rx_q[4], 15'h00ee);
      chk("ro2", rx_q[5], 15'h00ee);
      chk("rowr", wr_cnt, 15'h0002);
      chk("rorej", rej_cnt, 15'h0001);
   endtask

   task automatic t_zero();
      int o0;
      o0 = ovr_cnt;
      xchg(15'h0100, 1'b0, 8'h00, 1);
      chk("zhdr", rx_q[2], 15'h0055);
      chk("zee", rx_q[3], 15'h00ee);
      chk("zwr", wr_cnt, 15'h0002);
      chk("zovr", ovr_cnt - o0, 15'h0001);
   endtask

   task automatic t_rst();
      xchg(15'h0040, 1'b1, 8'h01, 1);
      chk("rclr", chg_oe, 15'h0000);
      @(posedge sys_clk_in);
      rst_in <= 1'b1;
      repeat (4) @(posedge sys_clk_in);
      chk("rsti", chg_oe, 15'h0000);
      rst_in <= 1'b0;
      repeat (10) @(posedge sys_clk_in);
      chk("rsto", chg_oe, 15'h0001);
      xchg(15'h0100, 1'b1, 8'h01, 1);
      chk("rhdr", rx_q[0], 15'h0055);
      chk("rhd2", rx_q[2], 15'h0055);
   endtask

   task automatic t_msg();
      chk("pend", chg_oe, 15'h0001);
      xchg(15'h0040, 1'b1, 8'h01, 1);
      chk("read", chg_oe, 15'h0000);
      @(posedge sys_clk_in);
      post <= 1'b1;
      @(posedge sys_clk_in);
      post <= 1'b0;
      repeat (4) @(posedge sys_clk_in);
      chk("post", chg_oe, 15'h0001);
   endtask

   task automatic t_sleep();
      @(posedge sys_clk_in);
      lpm <= 1'b1;
      repeat (8) @(posedge sys_clk_in);
      chk("deep", {deep, light, miso_oe}, 15'h0004);
      host_u.frame(1'b1);
      chk("light", {deep, light, miso_oe, busy}, 15'h0005);
      @(posedge sys_clk_in);
      lpm <= 1'b0;
      host_u.frame(1'b0);
      chk("wake", {deep, light, busy}, 15'h0000);
   endtask

   task automatic wrap_up();
      $display("checks %0d errors %0d", n_tests, num_errors);
      if (num_errors == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask

   initial begin
      repeat (8) @(posedge sys_clk_in);
      rst_in <= 1'b0;
      repeat (10) @(posedge sys_clk_in);
      t_msg();
      t_write();
      t_read();
      t_ro();
      t_zero();
      t_sleep();
      t_rst();
      wrap_up();
   end
endmodule // ssm_spi_slave_bench

`default_nettype wire
